// >>> dv/sdpcd_ctrl_model.sv
// Purpose: Memory controller model driving the command and data pins.
// Assumes: Masks and write data go out two cycles after the command.
// Notes: Deselect cycles carry a mode-set pattern with a flipped address.
`timescale 1ns/1ns
module sdpcd_ctrl_model (
   // Clock
   input  wire logic                       core_clk,
   // Pins towards the device
   output sdpcd_pkg::sdpcd_pins_t          pins,
   output logic [sdpcd_pkg::DATA_W-1:0]    data_pins_in
);
   // Idle pins at time zero
   initial begin
      pins = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
      data_pins_in = 16'h0000;
   end
   // One command, then deselect, then the mask and data beat
   task automatic send(input logic [2:0] rcw, input logic [1:0] bk, input logic [12:0] ad,
                       input logic [1:0] m, input logic [15:0] d);
      @(negedge core_clk);
      pins.cs_n = 1'b0;
      {pins.ras_n, pins.cas_n, pins.we_n} = rcw;
      pins.bank = bk;
      pins.address_lines = ad;
      @(negedge core_clk);
      pins.cs_n = 1'b1; // Strobes that a careless decoder would obey
      {pins.ras_n, pins.cas_n, pins.we_n} = 3'b000;
      pins.address_lines = ~ad;
      @(negedge core_clk);
      {pins.upper_byte_mask, pins.lower_byte_mask} = m;
      data_pins_in = d;
      @(negedge core_clk);
      {pins.upper_byte_mask, pins.lower_byte_mask} = ~m;
      data_pins_in = ~d; // Released lines show no stale value
   endtask
endmodule

// >>> dv/sdpcd_top_asserts.sv
// Purpose: Port timing checks for the pin command decode block.
// Assumes: Pins sampled at N show in the registered outputs after N+1.
// Notes: Bound into every sdpcd_top instance.
`timescale 1ns/1ns
module sdpcd_top_asserts #(
   parameter int PRECHG_CYC = 2
) (
   // Clock and reset
   input wire logic                            core_clk,
   input wire logic                            reset_n,
   // Pins
   input wire sdpcd_pkg::sdpcd_pins_t          pins,
   input wire logic [sdpcd_pkg::DATA_W-1:0]    data_pins_oe_q,
   // Array side
   input wire sdpcd_pkg::sdpcd_dec_t           dec_q,
   input wire logic [sdpcd_pkg::NUM_LANES-1:0] array_wr_en_q,
   input wire logic [sdpcd_pkg::ADDR_W-1:0]    mode_q,
   input wire logic [sdpcd_pkg::NUM_BANKS-1:0] bank_active_q,
   input wire logic [sdpcd_pkg::ADDR_W-1:0]    row_q [sdpcd_pkg::NUM_BANKS]
);
   localparam int PC2 = PRECHG_CYC + 2;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // Selected command with strobes ras, cas, we
   sequence sel_s(logic [2:0] rcw);
      !pins.cs_n && {pins.ras_n, pins.cas_n, pins.we_n} == rcw;
   endsequence
   // Column access then the data beat two edges later
   sequence beat_s(logic [2:0] rcw);
      sel_s(rcw) ##2 1'b1;
   endsequence
   desel_nop_a: assert property (pins.cs_n |-> ##2 dec_q.cmd == sdpcd_pkg::SDPCD_NOP)
      else $error("command decoded while deselected");
   open_row_a: assert property (sel_s(3'b011) |-> ##2 dec_q.cmd == sdpcd_pkg::SDPCD_OPEN
      && row_q[$past(pins.bank, 2)] == $past(pins.address_lines, 2) && bank_active_q[$past(pins.bank, 2)])
      else $error("bank open decode wrong");
   prechg_dec_a: assert property (sel_s(3'b010) |-> ##2 dec_q.cmd == sdpcd_pkg::SDPCD_PRECHG
      && dec_q.all_banks == $past(pins.address_lines[10], 2)) else $error("precharge decode wrong");
   read_dec_a: assert property (sel_s(3'b101) |-> ##2 dec_q.cmd == sdpcd_pkg::SDPCD_READ
      && dec_q.col == $past(pins.address_lines[8:0], 2) && dec_q.auto_prechg == $past(pins.address_lines[10], 2))
      else $error("read decode wrong");
   write_dec_a: assert property (sel_s(3'b100) |-> ##2 dec_q.cmd == sdpcd_pkg::SDPCD_WRITE
      && dec_q.col == $past(pins.address_lines[8:0], 2) && dec_q.auto_prechg == $past(pins.address_lines[10], 2))
      else $error("write decode wrong");
   mode_load_a: assert property (sel_s(3'b000) |-> ##2 mode_q == $past(pins.address_lines, 2))
      else $error("mode code not loaded");
   close_all_a: assert property (sel_s(3'b010) ##0 pins.address_lines[10] |-> ##PC2 bank_active_q == 4'h0)
      else $error("banks not idle after close all");
   read_oe_a: assert property (beat_s(3'b101) |-> ##2 data_pins_oe_q ==
      {{8{!$past(pins.upper_byte_mask, 2)}}, {8{!$past(pins.lower_byte_mask, 2)}}}) else $error("read enable wrong");
   write_en_a: assert property (beat_s(3'b100) |-> ##2 array_wr_en_q ==
      {!$past(pins.upper_byte_mask, 2), !$past(pins.lower_byte_mask, 2)}) else $error("write strobe wrong");
endmodule
bind sdpcd_top sdpcd_top_asserts #(.PRECHG_CYC(PRECHG_CYC)) i_sdpcd_top_asserts (.core_clk(core_clk),
   .reset_n(reset_n), .pins(pins), .data_pins_oe_q(data_pins_oe_q), .dec_q(dec_q), .array_wr_en_q(array_wr_en_q),
   .mode_q(mode_q), .bank_active_q(bank_active_q), .row_q(row_q));

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the pin command decode block.
// Assumes: Inputs change at falling edges only.
// Notes: Decode timing is judged by the bound checker.
`timescale 1ns/1ns
module testbench;
   logic                        core_clk = 1'b0;
   logic                        reset_n = 1'b0;
   sdpcd_pkg::sdpcd_pins_t      pins;
   sdpcd_pkg::sdpcd_dec_t       dec_q;
   logic [15:0]                 data_pins_in, data_pins_out_q, data_pins_oe_q, array_wr_data_q;
   logic [15:0]                 array_rd_data = 16'hBEEF;
   logic [1:0]                  array_wr_en_q;
   logic [12:0]                 mode_q;
   logic [3:0]                  bank_active_q;
   logic [12:0]                 row_q [4];
   int                          num_errors = 0;
   int                          cmp_count = 0;
   // Clock
   always #5 core_clk = ~core_clk;
   // Design and controller model
   sdpcd_top i_sdpcd_top (.core_clk(core_clk), .reset_n(reset_n), .pins(pins), .data_pins_in(data_pins_in),
      .data_pins_out_q(data_pins_out_q), .data_pins_oe_q(data_pins_oe_q), .array_rd_data(array_rd_data),
      .dec_q(dec_q), .array_wr_data_q(array_wr_data_q), .array_wr_en_q(array_wr_en_q), .mode_q(mode_q),
      .bank_active_q(bank_active_q), .row_q(row_q));
   sdpcd_ctrl_model i_sdpcd_ctrl_model (.core_clk(core_clk), .pins(pins), .data_pins_in(data_pins_in));
   // Compare and count
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Mode set, then deselects that look like mode sets
   task automatic t_mode;
      i_sdpcd_ctrl_model.send(3'b000, 2'h0, 13'h1A5A, 2'h0, 16'h0000);
      repeat (3) @(negedge core_clk);
      chk("mode", 16'h1A5A, {3'h0, mode_q});
   endtask
   // Open two banks
   task automatic t_open;
      i_sdpcd_ctrl_model.send(3'b011, 2'h2, 13'h1F0F, 2'h0, 16'h0000);
      i_sdpcd_ctrl_model.send(3'b011, 2'h0, 13'h0123, 2'h0, 16'h0000);
      chk("active", 16'h0005, {12'h0, bank_active_q});
      chk("row 2", 16'h1F0F, {3'h0, row_q[2]});
      chk("row 0", 16'h0123, {3'h0, row_q[0]});
   endtask
   // Close one bank, then all with only bank 0 still open
   task automatic t_prechg;
      i_sdpcd_ctrl_model.send(3'b010, 2'h2, 13'h0000, 2'h0, 16'h0000);
      repeat (2) @(negedge core_clk);
      chk("active", 16'h0001, {12'h0, bank_active_q});
      i_sdpcd_ctrl_model.send(3'b010, 2'h1, 13'h0400, 2'h0, 16'h0000);
      repeat (2) @(negedge core_clk);
      chk("active", 16'h0000, {12'h0, bank_active_q});
   endtask
   // Reads and writes under every mask pair
   task automatic t_masks;
      logic [1:0]  m;
      logic [15:0] e;
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         e = {{8{~m[1]}}, {8{~m[0]}}};
         i_sdpcd_ctrl_model.send(3'b101, 2'h1, {2'h0, m[0], 10'h0AB}, m, 16'h0000);
         @(negedge core_clk);
         chk("read enable", e, data_pins_oe_q);
         chk("read data", 16'hBEEF & e, data_pins_out_q & e);
         i_sdpcd_ctrl_model.send(3'b100, 2'h3, {2'h0, m[1], 10'h1A5}, m, 16'hA55A);
         @(negedge core_clk);
         chk("write strobe", {14'h0, ~m}, {14'h0, array_wr_en_q});
         chk("write data", 16'hA55A & e, array_wr_data_q & e);
      end
   endtask
   // Main sequence
   initial begin
      repeat (12) @(negedge core_clk);
      reset_n = 1'b1;
      t_mode();
      t_open();
      t_prechg();
      t_masks();
      conclude();
   end
   // Watchdog
   initial begin
      #100000;
      num_errors++;
      conclude();
   end
endmodule

// >>> rtl/sdpcd_lane.sv
// Purpose: One byte lane of the data pins with its mask.
// Assumes: Mask sampled on the same edge as the data.
// Notes: Instantiated once per byte lane.
`timescale 1ns/1ns
module sdpcd_lane #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   // Control
   input  wire logic         mask,
   input  wire logic         rd_act,
   input  wire logic         wr_act,
   input  wire logic [W-1:0] rd_data,
   input  wire logic [W-1:0] pin_in,
   // Results
   output logic [W-1:0]      pin_out_q,
   output logic              pin_oe_q,
   output logic [W-1:0]      wr_data_q,
   output logic              wr_en_q
);
   // Read drivers, enabled only when the lane is unmasked
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out_q <= '0;
         pin_oe_q  <= 1'b0;
      end else begin
         pin_oe_q  <= rd_act & ~mask;
         pin_out_q <= rd_data;
      end
   end

   // Write capture, masked bytes get no write enable
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_data_q <= '0;
         wr_en_q   <= 1'b0;
      end else begin
         wr_en_q   <= wr_act & ~mask;
         wr_data_q <= pin_in;
      end
   end
endmodule

// >>> rtl/sdpcd_pkg.sv
// Purpose: Shared constants and carrier types for the SDRAM pin command decode block.
// Assumes: Four banks, 13 address lines, 16 data pins split into two byte lanes.
package sdpcd_pkg;
   localparam int ADDR_W      = 13;
   localparam int COL_W       = 9;
   localparam int BANK_W      = 2;
   localparam int NUM_BANKS   = 4;
   localparam int DATA_W      = 16;
   localparam int LANE_W      = 8;
   localparam int NUM_LANES   = 2;
   localparam int AP_BIT      = 10;
   localparam int PRECHG_CYC  = 2;
   localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;

   typedef enum logic [2:0] {
      SDPCD_NOP,
      SDPCD_OPEN,
      SDPCD_PRECHG,
      SDPCD_READ,
      SDPCD_WRITE,
      SDPCD_MRS,
      SDPCD_OTHER
   } sdpcd_cmd_t;

   // Pins as seen from the controller, sampled each rising edge
   typedef struct packed {
      logic                  cs_n;
      logic                  ras_n;
      logic                  cas_n;
      logic                  we_n;
      logic [BANK_W-1:0]     bank;
      logic [ADDR_W-1:0]     address_lines;
      logic                  lower_byte_mask;
      logic                  upper_byte_mask;
   } sdpcd_pins_t;

   // Decoded command towards the array
   typedef struct packed {
      sdpcd_cmd_t            cmd;
      logic [BANK_W-1:0]     bank;
      logic [ADDR_W-1:0]     row;
      logic [COL_W-1:0]      col;
      logic                  auto_prechg;
      logic                  all_banks;
   } sdpcd_dec_t;
endpackage

// >>> rtl/sdpcd_top.sv
// Purpose: Command and address decode at the SDRAM pin interface with bank state.
// Assumes: All pins synchronous to core_clk; controller keeps the timing it owes.
// Notes: Read data path is single-beat per command; bursts are outside this block.
`timescale 1ns/1ns
module sdpcd_top #(
   parameter int PRECHG_CYC = sdpcd_pkg::PRECHG_CYC
) (
   // Clock and reset
   input  wire logic                                core_clk,
   input  wire logic                                reset_n,
   // Command pins
   input  wire sdpcd_pkg::sdpcd_pins_t              pins,
   // Data pins, split into three signals
   input  wire logic [sdpcd_pkg::DATA_W-1:0]        data_pins_in,
   output logic [sdpcd_pkg::DATA_W-1:0]             data_pins_out_q,
   output logic [sdpcd_pkg::DATA_W-1:0]             data_pins_oe_q,
   // Array side
   input  wire logic [sdpcd_pkg::DATA_W-1:0]        array_rd_data,
   output sdpcd_pkg::sdpcd_dec_t                    dec_q,
   output logic [sdpcd_pkg::DATA_W-1:0]             array_wr_data_q,
   output logic [sdpcd_pkg::NUM_LANES-1:0]          array_wr_en_q,
   output logic [sdpcd_pkg::ADDR_W-1:0]             mode_q,
   output logic [sdpcd_pkg::NUM_BANKS-1:0]          bank_active_q,
   output logic [sdpcd_pkg::ADDR_W-1:0]             row_q [sdpcd_pkg::NUM_BANKS]
);
   sdpcd_pkg::sdpcd_pins_t pins_q;
   logic [sdpcd_pkg::DATA_W-1:0] data_in_q;
   sdpcd_pkg::sdpcd_cmd_t  cmd_d;
   logic                   rd_act_q;
   logic                   wr_act_q;
   logic [sdpcd_pkg::NUM_BANKS-1:0] close_mask_q;
   logic [7:0]             prechg_cnt_q;
   logic [sdpcd_pkg::NUM_LANES-1:0] mask_bits;

   // Register every pin on the rising edge; data rides with the masks so both come from one edge
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pins_q    <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
         data_in_q <= '0;
      end else begin
         pins_q    <= pins;
         data_in_q <= data_pins_in;
      end
   end

   // Decode the registered strobes
   always_comb begin
      cmd_d = sdpcd_pkg::SDPCD_NOP;
      if (pins_q.cs_n) begin
         cmd_d = sdpcd_pkg::SDPCD_NOP;
      end else begin
         case ({pins_q.ras_n, pins_q.cas_n, pins_q.we_n})
            3'b011: cmd_d = sdpcd_pkg::SDPCD_OPEN;
            3'b010: cmd_d = sdpcd_pkg::SDPCD_PRECHG;
            3'b101: cmd_d = sdpcd_pkg::SDPCD_READ;
            3'b100: cmd_d = sdpcd_pkg::SDPCD_WRITE;
            3'b000: cmd_d = sdpcd_pkg::SDPCD_MRS;
            3'b111: cmd_d = sdpcd_pkg::SDPCD_NOP;
            default: cmd_d = sdpcd_pkg::SDPCD_OTHER;
         endcase
      end
   end

   // Decoded command with address fields
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dec_q <= '{cmd: sdpcd_pkg::SDPCD_NOP, default: '0};
      end else begin
         dec_q.cmd         <= cmd_d;
         dec_q.bank        <= pins_q.bank;
         dec_q.row         <= pins_q.address_lines;
         dec_q.col         <= pins_q.address_lines[sdpcd_pkg::COL_W-1:0];
         dec_q.auto_prechg <= pins_q.address_lines[sdpcd_pkg::AP_BIT] &
                              (cmd_d == sdpcd_pkg::SDPCD_READ || cmd_d == sdpcd_pkg::SDPCD_WRITE);
         dec_q.all_banks   <= pins_q.address_lines[sdpcd_pkg::AP_BIT] &
                              (cmd_d == sdpcd_pkg::SDPCD_PRECHG);
      end
   end

   // Mode register load
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= sdpcd_pkg::MODE_RST;
      end else if (cmd_d == sdpcd_pkg::SDPCD_MRS) begin
         mode_q <= pins_q.address_lines;
      end
   end

   // Row latch per bank on bank open
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int b = 0; b < sdpcd_pkg::NUM_BANKS; b++) begin
            row_q[b] <= '0;
         end
      end else if (cmd_d == sdpcd_pkg::SDPCD_OPEN) begin
         row_q[pins_q.bank] <= pins_q.address_lines;
      end
   end

   // Precharge timer; banks go idle when it expires
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prechg_cnt_q <= '0;
         close_mask_q <= '0;
      end else if (cmd_d == sdpcd_pkg::SDPCD_PRECHG) begin
         prechg_cnt_q <= 8'(PRECHG_CYC);
         if (pins_q.address_lines[sdpcd_pkg::AP_BIT]) begin
            close_mask_q <= close_mask_q | {sdpcd_pkg::NUM_BANKS{1'b1}};
         end else begin
            close_mask_q <= close_mask_q | (4'h1 << pins_q.bank);
         end
      end else if (prechg_cnt_q > 8'h01) begin
         prechg_cnt_q <= prechg_cnt_q - 8'h01;
      end else if (prechg_cnt_q == 8'h01) begin
         prechg_cnt_q <= '0;
         close_mask_q <= '0;
      end
   end

   // Bank state: open sets, completed precharge clears
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bank_active_q <= '0;
      end else begin
         for (int b = 0; b < sdpcd_pkg::NUM_BANKS; b++) begin
            if (cmd_d == sdpcd_pkg::SDPCD_OPEN && pins_q.bank == 2'(b)) begin
               bank_active_q[b] <= 1'b1;
            end else if (prechg_cnt_q == 8'h01 && close_mask_q[b]) begin
               bank_active_q[b] <= 1'b0;
            end
         end
      end
   end

   // Column access direction, one stage after the decode so it meets the mask and data beat
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
      end else begin
         rd_act_q <= (dec_q.cmd == sdpcd_pkg::SDPCD_READ);
         wr_act_q <= (dec_q.cmd == sdpcd_pkg::SDPCD_WRITE);
      end
   end

   // Lane masks: lower governs bits 7..0, upper 15..8
   assign mask_bits = {pins_q.upper_byte_mask, pins_q.lower_byte_mask};

   // One data lane per byte
   for (genvar g = 0; g < sdpcd_pkg::NUM_LANES; g++) begin : g_lane
      logic                         lane_oe;
      sdpcd_lane #(.W(sdpcd_pkg::LANE_W)) u_lane (
         .core_clk  (core_clk),
         .reset_n   (reset_n),
         .mask      (mask_bits[g]),
         .rd_act    (rd_act_q),
         .wr_act    (wr_act_q),
         .rd_data   (array_rd_data[g*sdpcd_pkg::LANE_W +: sdpcd_pkg::LANE_W]),
         .pin_in    (data_in_q[g*sdpcd_pkg::LANE_W +: sdpcd_pkg::LANE_W]),
         .pin_out_q (data_pins_out_q[g*sdpcd_pkg::LANE_W +: sdpcd_pkg::LANE_W]),
         .pin_oe_q  (lane_oe),
         .wr_data_q (array_wr_data_q[g*sdpcd_pkg::LANE_W +: sdpcd_pkg::LANE_W]),
         .wr_en_q   (array_wr_en_q[g])
      );
      assign data_pins_oe_q[g*sdpcd_pkg::LANE_W +: sdpcd_pkg::LANE_W] = {sdpcd_pkg::LANE_W{lane_oe}};
   end
endmodule
